// ### core/immediate_io_instruction_unit.v
// Execution unit for the immediate I/O instructions of the controller CPU
`timescale 1ns/1ps

`include "imm_io_defs.vh"

module immediate_io_instruction_unit #(
  parameter N_PTS = 1024,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire                  i_clock,
  input  wire                  i_rst,
  // Instruction from the sequencer
  input  wire                  i_op_valid,
  input  wire [`OP_W-1:0]      i_opcode,
  input  wire [AW-1:0]         i_addr,
  input  wire [`VADDR_W-1:0]   i_vaddr,
  input  wire [`CNT_W-1:0]     i_count,
  input  wire                  i_rung,
  input  wire [`ACC_W-1:0]     i_acc,
  input  wire                  i_scan_start,
  // Result to the sequencer
  output reg                   o_ready,
  output reg                   o_done,
  output reg                   o_rung,
  output reg  [`ACC_W-1:0]     o_acc,
  output reg                   o_acc_we,
  // Image register access by normal scan logic
  input  wire                  i_img_we,
  input  wire [AW-1:0]         i_img_addr,
  input  wire                  i_img_data,
  input  wire                  i_refresh,
  // Local base points
  input  wire [N_PTS-1:0]      i_in_points,
  output reg  [N_PTS-1:0]      o_out_points,
  output reg  [N_PTS-1:0]      o_out_image
);

  // One-hot states, two edges per instruction
  localparam S_IDLE = 2'h1;
  localparam S_EXEC = 2'h2;

  // =====================================================
  // Helpers
  function [`ACC_W-1:0] field_mask;
    input [`CNT_W-1:0] cnt;
    integer k;
    begin
      field_mask = {`ACC_W{1'b0}};
      for (k = 0; k < `ACC_W; k = k + 1)
        field_mask[k] = (k < cnt);
    end
  endfunction

  function is_contact;
    input [`OP_W-1:0] op;
    begin
      is_contact = (op == `OP_SERIES_LIVE) || (op == `OP_SERIES_INV);
    end
  endfunction

  // =====================================================
  // State and captured operands
  reg  [1:0]          state_r;
  reg  [1:0]          state_nxt;
  reg  [`OP_W-1:0]    op_r;
  reg  [AW-1:0]       addr_r;
  reg  [`CNT_W-1:0]   cnt_r;
  reg                 rung_r;
  reg  [`ACC_W-1:0]   acc_r;

  wire                take;
  wire                exec;
  wire [`VADDR_W-1:0] word_off;
  wire [AW-1:0]       word_bit;
  wire [AW-1:0]       rd_base;
  wire [`CNT_W-1:0]   rd_cnt;
  wire [`ACC_W-1:0]   live_field;
  wire                acc_rd;
  wire                or_bit;
  wire [`ACC_W-1:0]   wr_mask;
  wire [N_PTS-1:0]    one_hot;
  wire [N_PTS-1:0]    range_mask;
  wire [N_PTS-1:0]    field_data;

  assign take = i_op_valid && o_ready;
  assign exec = (state_r == S_EXEC);

  // =====================================================
  // Live input sampling, image untouched
  assign word_off = i_vaddr - `WORD_BASE;
  assign word_bit = {word_off[AW-`WORD_SHIFT-1:0], {`WORD_SHIFT{1'b0}}};
  assign rd_base  = (i_opcode == `OP_WORD_LD) ? word_bit : i_addr;
  assign rd_cnt   = is_contact(i_opcode) ? `CNT_ONE :
                    (i_opcode == `OP_WORD_LD) ? `WORD_BITS : i_count;

  // Sample lands in the cycle of execution, one edge after acceptance
  point_field #(
    .N_PTS (N_PTS),
    .AW    (AW)
  ) u_live (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_en    (take),
    .i_vec   (i_in_points),
    .i_base  (rd_base),
    .i_mask  (field_mask(rd_cnt)),
    .o_field (live_field)
  );

  // =====================================================
  // OR accumulation per output
  // Read address follows the request, so the sum is ready in the execute cycle
  assign or_bit = acc_rd | rung_r;

  or_acc_mem #(
    .DEPTH (N_PTS),
    .AW    (AW)
  ) u_or_acc (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_clear (i_scan_start),
    .i_we    (exec && (op_r == `OP_OR_COIL)),
    .i_waddr (addr_r),
    .i_wdata (or_bit),
    .i_raddr (i_addr),
    .o_rdata (acc_rd)
  );

  // =====================================================
  // Output point masks
  assign wr_mask    = field_mask(cnt_r);
  assign one_hot    = {{(N_PTS-1){1'b0}}, 1'b1} << addr_r;
  assign range_mask = {{(N_PTS-`ACC_W){1'b0}}, wr_mask} << addr_r;
  assign field_data = {{(N_PTS-`ACC_W){1'b0}}, acc_r & wr_mask} << addr_r;

  reg [N_PTS-1:0] set_v;
  reg [N_PTS-1:0] clr_v;

  always @*
  begin
    set_v = {N_PTS{1'b0}};
    clr_v = {N_PTS{1'b0}};
    if (exec)
    begin
      case (op_r)
        `OP_COIL:
        begin
          clr_v = one_hot;
          set_v = rung_r ? one_hot : {N_PTS{1'b0}};
        end
        `OP_OR_COIL:
        begin
          clr_v = one_hot;
          set_v = or_bit ? one_hot : {N_PTS{1'b0}};
        end
        `OP_FIELD_WR:
        begin
          clr_v = rung_r ? range_mask : {N_PTS{1'b0}};
          set_v = rung_r ? field_data : {N_PTS{1'b0}};
        end
        `OP_LATCH_ON:
          set_v = rung_r ? range_mask : {N_PTS{1'b0}};
        `OP_LATCH_OFF:
          clr_v = rung_r ? range_mask : {N_PTS{1'b0}};
        default:
        begin
          set_v = {N_PTS{1'b0}};
          clr_v = {N_PTS{1'b0}};
        end
      endcase
    end
  end

  // =====================================================
  // Sequencing
  always @*
  begin
    case (state_r)
      S_IDLE:  state_nxt = take ? S_EXEC : S_IDLE;
      S_EXEC:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_r <= S_IDLE;
      o_ready <= 1'b0;
      op_r    <= `OP_NONE;
      addr_r  <= {AW{1'b0}};
      cnt_r   <= {`CNT_W{1'b0}};
      rung_r  <= 1'b0;
      acc_r   <= {`ACC_W{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      o_ready <= (state_nxt == S_IDLE);
      if (take)
      begin
        op_r   <= i_opcode;
        addr_r <= i_addr;
        // Clamp, so a bad operand cannot reach past the accumulator width
        cnt_r  <= (i_count > `CNT_MAX) ? `CNT_MAX : i_count;
        rung_r <= i_rung;
        acc_r  <= i_acc;
      end
    end
  end

  // =====================================================
  // Results to the sequencer
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_done   <= 1'b0;
      o_rung   <= 1'b0;
      o_acc    <= {`ACC_W{1'b0}};
      o_acc_we <= 1'b0;
    end
    else
    begin
      o_done   <= exec;
      o_acc_we <= 1'b0;
      if (exec)
      begin
        case (op_r)
          `OP_SERIES_LIVE:
            o_rung <= rung_r & live_field[0];
          `OP_SERIES_INV:
            o_rung <= rung_r & ~live_field[0];
          `OP_WORD_LD, `OP_FIELD_RD:
          begin
            o_rung <= rung_r;
            if (rung_r)
            begin
              o_acc    <= live_field;
              o_acc_we <= 1'b1;
            end
          end
          `OP_FIELD_WR:
          begin
            o_rung <= rung_r;
            if (rung_r)
            begin
              o_acc    <= acc_r & wr_mask;
              o_acc_we <= 1'b1;
            end
          end
          default:
            o_rung <= rung_r;
        endcase
      end
    end
  end

  // =====================================================
  // Output image and module points
  // Immediate writes hit both at once; scan writes touch the image only
  // Scan writes yield to an executing instruction, which owns both vectors then
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_out_points <= {N_PTS{1'b0}};
      o_out_image  <= {N_PTS{1'b0}};
    end
    else if (exec)
    begin
      o_out_points <= (o_out_points & ~clr_v) | set_v;
      o_out_image  <= (o_out_image & ~clr_v) | set_v;
    end
    else
    begin
      if (i_img_we)
        o_out_image[i_img_addr] <= i_img_data;
      if (i_refresh)
        o_out_points <= o_out_image;
    end
  end

endmodule // immediate_io_instruction_unit

// ### pkg/imm_io_defs.vh
// Constants shared by the immediate I/O instruction unit
`ifndef IMM_IO_DEFS_VH
`define IMM_IO_DEFS_VH

// =====================================================
// Instruction codes from the sequencer
`define OP_W            4
`define OP_NONE         4'h0
`define OP_SERIES_LIVE  4'h1
`define OP_SERIES_INV   4'h2
`define OP_COIL         4'h3
`define OP_OR_COIL      4'h4
`define OP_FIELD_WR     4'h5
`define OP_LATCH_ON     4'h6
`define OP_LATCH_OFF    4'h7
`define OP_WORD_LD      4'h8
`define OP_FIELD_RD     4'h9

// =====================================================
// Field and word sizes
`define ACC_W           32
`define CNT_W           6
`define CNT_ONE         6'h01
`define CNT_MAX         6'h20
`define WORD_BITS       6'h10
`define WORD_SHIFT      4

// =====================================================
// Input word-memory window (V-address of first input word)
`define VADDR_W         15
`define WORD_BASE       15'h4100

`endif

// ### core/or_acc_mem.v
// Bit memory holding the per-output OR accumulation of the current scan
`timescale 1ns/1ps

module or_acc_mem #(
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire          i_clock,
  input  wire          i_rst,
  // Clear of every bit
  input  wire          i_clear,
  // Write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire          i_wdata,
  // Read port
  input  wire [AW-1:0] i_raddr,
  output reg           o_rdata
);

  reg [DEPTH-1:0] bits_r;

  // =====================================================
  // Storage, clear has priority so a new scan starts clean
  always @(posedge i_clock)
  begin
    if (i_rst || i_clear)
      bits_r <= {DEPTH{1'b0}};
    else if (i_we)
      bits_r[i_waddr] <= i_wdata;
  end

  // =====================================================
  // Registered read
  always @(posedge i_clock)
  begin
    if (i_rst || i_clear)
      o_rdata <= 1'b0;
    else
      o_rdata <= bits_r[i_raddr];
  end

endmodule // or_acc_mem

// ### core/point_field.v
// Registered extraction of up to 32 consecutive live points
`timescale 1ns/1ps

`include "imm_io_defs.vh"

module point_field #(
  parameter N_PTS = 1024,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire              i_clock,
  input  wire              i_rst,
  // Sample request
  input  wire              i_en,
  input  wire [N_PTS-1:0]  i_vec,
  input  wire [AW-1:0]     i_base,
  input  wire [`ACC_W-1:0] i_mask,
  // Sampled field, unused bits zero
  output reg  [`ACC_W-1:0] o_field
);

  wire [N_PTS-1:0] shifted;

  assign shifted = i_vec >> i_base;

  // =====================================================
  // Sample taken only on request, so the value is that of the accepting cycle
  always @(posedge i_clock)
  begin
    if (i_rst)
      o_field <= {`ACC_W{1'b0}};
    else if (i_en)
      o_field <= shifted[`ACC_W-1:0] & i_mask;
  end

endmodule // point_field

// ### tb/imm_io_props.sv
// Concurrent checks on the immediate I/O instruction unit ports
`timescale 1ns/1ps
`include "imm_io_defs.vh"
module imm_io_props #(
  parameter N_PTS = 64,
  parameter AW    = 6
) (
  // Clock and reset
  input wire              i_clock,
  input wire              i_rst,
  // Request
  input wire              i_op_valid,
  input wire [`OP_W-1:0]  i_opcode,
  input wire [AW-1:0]     i_addr,
  input wire [`CNT_W-1:0] i_count,
  input wire              i_rung,
  input wire [`ACC_W-1:0] i_acc,
  input wire [N_PTS-1:0]  i_in_points,
  // Results
  input wire              o_ready,
  input wire              o_done,
  input wire              o_rung,
  input wire [`ACC_W-1:0] o_acc,
  input wire              o_acc_we,
  input wire [N_PTS-1:0]  o_out_points,
  input wire [N_PTS-1:0]  o_out_image
);
  // ==========================================
  // Request capture, held until the done cycle
  reg [`OP_W-1:0]  t_op;
  reg [AW-1:0]     t_a;
  reg [`CNT_W-1:0] t_c;
  reg              t_r;
  reg              t_b;
  reg [`ACC_W-1:0] t_acc;
  wire take = i_op_valid & o_ready;
  always @(posedge i_clock)
  begin
    if (take)
    begin
      t_op  <= i_opcode;
      t_a   <= i_addr;
      t_c   <= i_count;
      t_r   <= i_rung;
      t_b   <= i_in_points[i_addr];
      t_acc <= i_acc;
    end
  end
  wire fin = o_done & t_r & (t_c != 6'h00);
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  done_latency_a: assert property (take |=> !o_ready ##1 o_done) else $error("done late or early");
  done_pulse_a: assert property (o_done |=> !o_done) else $error("done wider than one cycle");
  acc_we_a: assert property (o_acc_we |-> o_done) else $error("acc write outside done");
  live_contact_a: assert property (o_done && t_op == `OP_SERIES_LIVE |-> o_rung == (t_r & t_b))
    else $error("live contact result wrong");
  inv_contact_a: assert property (o_done && t_op == `OP_SERIES_INV |-> o_rung == (t_r & ~t_b))
    else $error("inverted contact result wrong");
  image_kept_a: assert property (o_done && (t_op == `OP_SERIES_LIVE || t_op == `OP_SERIES_INV)
    |-> $stable(o_out_image)) else $error("contact changed image");
  coil_write_a: assert property (o_done && t_op == `OP_COIL
    |-> o_out_points[t_a] == t_r && o_out_image[t_a] == t_r) else $error("coil not written");
  field_wr_a: assert property (fin && t_op == `OP_FIELD_WR |-> o_out_points[t_a] == t_acc[0])
    else $error("field write first bit wrong");
  latch_on_a: assert property (fin && t_op == `OP_LATCH_ON |-> o_out_points[t_a] && o_out_image[t_a])
    else $error("latch on missed");
  latch_off_a: assert property (fin && t_op == `OP_LATCH_OFF |-> !o_out_points[t_a] && !o_out_image[t_a])
    else $error("latch off missed");
  field_zero_a: assert property (o_acc_we && t_op == `OP_FIELD_RD && t_c < 6'h20 |-> (o_acc >> t_c) == 0)
    else $error("unused acc bits not zero");
endmodule // imm_io_props

bind immediate_io_instruction_unit imm_io_props #(.N_PTS(N_PTS), .AW(AW)) i_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_opcode(i_opcode), .i_addr(i_addr),
  .i_count(i_count), .i_rung(i_rung), .i_acc(i_acc), .i_in_points(i_in_points), .o_ready(o_ready),
  .o_done(o_done), .o_rung(o_rung), .o_acc(o_acc), .o_acc_we(o_acc_we), .o_out_points(o_out_points),
  .o_out_image(o_out_image));

// ### tb/io_base_model.sv
// Behavioural local base input modules
`timescale 1ns/1ps
module io_base_model #(
  parameter N_PTS = 64
) (
  // Clock and field side
  input  wire             i_clock,
  input  wire [N_PTS-1:0] i_drive,
  // Live input points
  output reg  [N_PTS-1:0] o_in_points
);
  // Points change every cycle, so stale sampling shows up
  initial o_in_points = {N_PTS{1'b0}};
  always @(posedge i_clock) o_in_points <= i_drive;
endmodule // io_base_model

// ### tb/immediate_io_instruction_unit_bench.sv
// Self-checking bench for the immediate I/O instruction unit
`timescale 1ns/1ps
module immediate_io_instruction_unit_bench;
  // ==========================================
  // Signals and model state
  reg         clock, rst, op_valid, rung, scan_start, img_we, img_data, refresh;
  reg  [3:0]  opcode;
  reg  [5:0]  addr, count, img_addr;
  reg  [14:0] vaddr;
  reg  [31:0] acc, e_acc, m;
  reg  [63:0] drive, snap, e_out, e_img, e_or;
  wire        ready, done, rung_o, acc_we;
  wire [31:0] acc_o;
  wire [63:0] in_pts, out_pts, out_img;
  integer     err_total, checks, seed, k, n, cn, i;
  reg         er, we;
  // ==========================================
  // Instances
  immediate_io_instruction_unit #(.N_PTS(64), .AW(6)) i_dut (.i_clock(clock), .i_rst(rst),
    .i_op_valid(op_valid), .i_opcode(opcode), .i_addr(addr), .i_vaddr(vaddr), .i_count(count),
    .i_rung(rung), .i_acc(acc), .i_scan_start(scan_start), .o_ready(ready), .o_done(done),
    .o_rung(rung_o), .o_acc(acc_o), .o_acc_we(acc_we), .i_img_we(img_we), .i_img_addr(img_addr),
    .i_img_data(img_data), .i_refresh(refresh), .i_in_points(in_pts), .o_out_points(out_pts), .o_out_image(out_img));
  io_base_model #(.N_PTS(64)) i_base (.i_clock(clock), .i_drive(drive), .o_in_points(in_pts));
  initial
  begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) drive <= {$random(seed), $random(seed)};
  // ==========================================
  // Tasks
  task chk(input [63:0] nm, input [63:0] seen, input [63:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task end_sim;
  begin
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end
  endtask
  task scan;
  begin
    @(posedge clock) scan_start <= 1;
    @(posedge clock) scan_start <= 0;
    e_or = 64'h0;
  end
  endtask
  // Scan-side image write, then an optional refresh, both outside any execute cycle
  task img(input [5:0] a, input d, input f);
  begin
    @(posedge clock) img_we <= 1; img_addr <= a; img_data <= d;
    @(posedge clock) img_we <= 0; refresh <= f;
    @(posedge clock) refresh <= 0;
    @(negedge clock);
    e_img[a] = d;
    if (f) e_out = e_img;
    chk("image", out_img, e_img);
    chk("points", out_pts, e_out);
  end
  endtask
  // Request held until taken; live points snapped just before the taking edge
  task run(input [3:0] op, input [5:0] a, input [14:0] va, input [5:0] c, input r, input [31:0] ac);
  begin
    @(posedge clock);
    op_valid <= 1; opcode <= op; addr <= a; vaddr <= va; count <= c; rung <= r; acc <= ac;
    n = 0;
    @(negedge clock);
    while (ready !== 1'b1 && n < 8) begin n = n + 1; @(negedge clock); end
    snap = in_pts;
    @(posedge clock) op_valid <= 0;
    n = 0;
    @(negedge clock);
    while (done !== 1'b1 && n < 4) begin n = n + 1; @(negedge clock); end
    cn = (c > 32) ? 32 : c;
    m = (cn == 32) ? 32'hFFFFFFFF : (32'h1 << cn) - 32'h1;
    er = r;
    we = r && (op == 5 || op == 8 || op == 9);
    case (op)
      1: er = r & snap[a];
      2: er = r & ~snap[a];
      3: begin e_out[a] = r; e_img[a] = r; end
      4: begin e_or[a] = e_or[a] | r; e_out[a] = e_or[a]; e_img[a] = e_or[a]; end
      5, 6, 7: if (r) for (i = 0; i < cn; i = i + 1) if (a + i < 64)
      begin
        e_out[a + i] = (op == 5) ? ac[i] : (op == 6);
        e_img[a + i] = e_out[a + i];
      end
      8: e_acc = {16'h0000, snap[(va - 15'h4100) * 16 +: 16]};
      9: e_acc = (snap >> a) & m;
    endcase
    if (op == 5) e_acc = ac & m;
    chk("done", done, 1);
    chk("rung", rung_o, er);
    chk("acc_we", acc_we, we);
    if (we) chk("acc", acc_o, e_acc);
    chk("points", out_pts, e_out);
    chk("image", out_img, e_img);
  end
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    rst = 1; op_valid = 0; opcode = 0; addr = 0; vaddr = 0; count = 0; rung = 0; acc = 0;
    scan_start = 0; drive = 0; seed = 32'hebffc360; err_total = 0; checks = 0;
    img_we = 0; img_addr = 0; img_data = 0; refresh = 0;
    e_out = 0; e_img = 0; e_or = 0; e_acc = 0;
    repeat (12) @(posedge clock);
    rst <= 0;
    for (k = 0; k < 16; k = k + 1) run(1 + k % 2, $random(seed), 0, 0, $random(seed), 0);
    $display("Test contacts ended");
    for (k = 0; k < 4; k = k + 1) run(3, 6'h05, 0, 0, k % 2, 0);
    scan; run(4, 6'h09, 0, 0, 0, 0); run(4, 6'h09, 0, 0, 1, 0); run(4, 6'h09, 0, 0, 0, 0);
    scan; run(4, 6'h09, 0, 0, 0, 0);
    $display("Test coils ended");
    run(5, 6'h00, 0, 6'h01, 1, $random(seed)); run(5, 6'h10, 0, 6'h20, 1, $random(seed));
    run(5, 6'h30, 0, 6'h21, 1, $random(seed)); run(5, 6'h08, 0, 6'h00, 1, $random(seed));
    run(5, 6'h04, 0, 6'h08, 0, $random(seed));
    $display("Test field write ended");
    run(6, 6'h02, 0, 6'h04, 1, 0); run(7, 6'h02, 0, 6'h04, 0, 0); run(6, 6'h3E, 0, 6'h20, 1, 0);
    run(7, 6'h03, 0, 6'h14, 1, 0); run(6, 6'h20, 0, 6'h08, 0, 0);
    $display("Test latches ended");
    img(6'h11, 1, 0); img(6'h12, 1, 1); img(6'h11, 0, 0); run(3, 6'h12, 0, 0, 0, 0); run(3, 6'h11, 0, 0, 1, 0);
    $display("Test image ended");
    for (k = 0; k < 5; k = k + 1) run(8, 0, 15'h4100 + k % 4, 0, k < 4, 0);
    for (k = 0; k < 6; k = k + 1) run(9, $random(seed), 0, k * 7, 1, 32'hFFFFFFFF);
    $display("Test loads ended");
    end_sim;
  end
  initial
  begin
    #(25 * 5000);
    err_total = err_total + 1;
    end_sim;
  end
endmodule // immediate_io_instruction_unit_bench
